// File: pkg/irmod_pkg.sv
package irmod_pkg;

   // Derivative register addresses
   localparam logic [2:0] ADDR_ON_LEN   = 3'h0;
   localparam logic [2:0] ADDR_OFF_LEN  = 3'h1;
   localparam logic [2:0] ADDR_CNT_LOW  = 3'h2;
   localparam logic [2:0] ADDR_CONTROL  = 3'h3;
   localparam logic [2:0] ADDR_CNT_HIGH = 3'h4;

   // Control register and count high bit positions
   localparam int CTRL_WDT_BIT   = 4;
   localparam int CTRL_RINT_BIT  = 3;
   localparam int CTRL_CONT_BIT  = 2;
   localparam int CTRL_LONG_BIT  = 1;
   localparam int CTRL_CHOP_BIT  = 0;
   localparam int CNT_HIGH_MSB   = 9;
   localparam int CNT_HIGH_LSB   = 8;

   // Reset values
   localparam logic [7:0] REG_RST   = 8'h00;
   localparam logic [9:0] CNT_RST   = 10'h000;
   localparam logic [2:0] MODE_RST  = 3'h0;
   localparam logic [8:0] TIMER_RST = 9'h000;
   localparam logic [1:0] PHASE_RST = 2'h0;

   // Timer loads value + 1 and runs through zero: value + 2 cycles
   localparam logic [8:0] TIMER_EXTRA = 9'h001;
   localparam logic [9:0] CNT_ONE     = 10'h001;
   localparam logic [1:0] PHASE_STEP  = 2'h1;
   localparam int         CHOP_BIT    = 1;

   // Core instruction kinds on the derivative port
   typedef enum logic [1:0]
   {
      DERIV_WRITE = 2'h0,
      DERIV_READ  = 2'h1,
      DERIV_AND   = 2'h2,
      DERIV_OR    = 2'h3
   } deriv_op_e;

   // Modulator sequence, Gray coded along idle, on, off
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ON   = 2'b01,
      ST_OFF  = 2'b11
   } mod_state_e;

endpackage : irmod_pkg

// File: src/ir_pulse_burst_modulator.sv
// Operation
// - ON time is register value plus two
// - OFF time is register value plus two
// - Ten-bit count split over two addresses
// - Control: three modes, two strobes, reserved
// - Control bit 4 pulses watchdog reload
// - Control bit 3 clears interrupt flag
// - Continuous mode ignores count, never stops
// - Long pulse: ON time times count
// - Long pulse chopped when carrier set
// - Carrier chops ON at quarter clock
// - Write and read move accumulator data
// - AND/OR read, combine, write back
// - After reset output high, inactive
// - Count load starts burst with ON
// - ON end decrements, then OFF, repeat
// - Count reaching zero sets interrupt
// - Count load clears interrupt flag
`timescale 1ns/1ps
`default_nettype none

module ir_pulse_burst_modulator
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       op_valid_i,
   input  wire logic [1:0] op_code_i,
   input  wire logic [2:0] op_addr_i,
   input  wire logic [7:0] acc_data_i,
   output var  logic [7:0] rd_data_o,
   output var  logic       rd_valid_o,
   output var  logic       pulse_out_n_o,
   output var  logic       mod_irq_o,
   output var  logic       watchdog_reload_strobe_o
);

   logic [7:0]             on_len_q;
   logic [7:0]             off_len_q;
   logic [9:0]             cnt_q;
   logic [2:0]             mode_q;
   logic [8:0]             timer_q;
   logic [1:0]             phase_q;
   irmod_pkg::mod_state_e  state_q;
   logic [7:0]             cur_val;
   logic [7:0]             new_val;
   logic                   wr_en;
   logic                   load_low;
   logic                   ctrl_wr;
   logic                   burst_done;
   logic                   cont_mode;
   logic                   long_mode;
   logic                   chop_mode;

   // Mode bits act live; continuous and long take effect at the next ON timer end, chop at once
   assign cont_mode = mode_q[irmod_pkg::CTRL_CONT_BIT];
   assign long_mode = mode_q[irmod_pkg::CTRL_LONG_BIT];
   assign chop_mode = mode_q[irmod_pkg::CTRL_CHOP_BIT];

   // Current contents of the addressed register; unmapped reads zero
   always_comb
   begin
      case (op_addr_i)
         irmod_pkg::ADDR_ON_LEN:   cur_val = on_len_q;
         irmod_pkg::ADDR_OFF_LEN:  cur_val = off_len_q;
         irmod_pkg::ADDR_CNT_LOW:  cur_val = cnt_q[7:0];
         irmod_pkg::ADDR_CONTROL:  cur_val = {5'h00, mode_q};
         irmod_pkg::ADDR_CNT_HIGH: cur_val = {6'h00, cnt_q[9:8]};
         default:                  cur_val = 8'h00;
      endcase
   end

   // Value written back by write, AND and OR instructions
   always_comb
   begin
      case (op_code_i)
         irmod_pkg::DERIV_AND: new_val = cur_val & acc_data_i;
         irmod_pkg::DERIV_OR:  new_val = cur_val | acc_data_i;
         default:              new_val = acc_data_i;
      endcase
   end

   // Instruction decode; AND and OR write back like a plain write
   assign wr_en    = op_valid_i && (op_code_i != irmod_pkg::DERIV_READ);
   assign load_low = wr_en && (op_addr_i == irmod_pkg::ADDR_CNT_LOW);
   assign ctrl_wr  = wr_en && (op_addr_i == irmod_pkg::ADDR_CONTROL);
   // Last ON end of a counted burst; a stray zero count ends at its first ON end too
   assign burst_done = (state_q == irmod_pkg::ST_ON) && (timer_q == 9'h000)
                       && !cont_mode && (cnt_q <= irmod_pkg::CNT_ONE);

   // Timing and mode registers
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         on_len_q  <= irmod_pkg::REG_RST;
         off_len_q <= irmod_pkg::REG_RST;
         mode_q    <= irmod_pkg::MODE_RST;
      end
      else if (wr_en)
      begin
         if (op_addr_i == irmod_pkg::ADDR_ON_LEN)
            on_len_q <= new_val;
         if (op_addr_i == irmod_pkg::ADDR_OFF_LEN)
            off_len_q <= new_val;
         if (ctrl_wr)
            mode_q <= new_val[irmod_pkg::CTRL_CONT_BIT:0];
      end
   end

   // Read answer, one cycle after the instruction
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rd_data_o  <= irmod_pkg::REG_RST;
         rd_valid_o <= 1'b0;
      end
      else
      begin
         rd_valid_o <= op_valid_i && (op_code_i == irmod_pkg::DERIV_READ);
         if (op_valid_i && (op_code_i == irmod_pkg::DERIV_READ))
            rd_data_o <= cur_val;
      end
   end

   // Watchdog reload is a strobe only, nothing is stored
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         watchdog_reload_strobe_o <= 1'b0;
      else
         watchdog_reload_strobe_o <= ctrl_wr
            && new_val[irmod_pkg::CTRL_WDT_BIT];
   end

   // Sequencer, pulse timer and burst count
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= irmod_pkg::ST_IDLE;
         timer_q <= irmod_pkg::TIMER_RST;
         cnt_q   <= irmod_pkg::CNT_RST;
         phase_q <= irmod_pkg::PHASE_RST;
      end
      else if (load_low)
      begin
         // A load restarts even a running burst
         cnt_q[7:0] <= new_val;
         state_q    <= irmod_pkg::ST_ON;
         timer_q    <= {1'b0, on_len_q} + irmod_pkg::TIMER_EXTRA;
         phase_q    <= irmod_pkg::PHASE_RST;
      end
      else
      begin
         case (state_q)
            irmod_pkg::ST_ON:
            begin
               phase_q <= phase_q + irmod_pkg::PHASE_STEP;
               if (timer_q != 9'h000)
                  timer_q <= timer_q - 9'h001;
               else if (cont_mode)
               begin
                  if (long_mode)
                     timer_q <= {1'b0, on_len_q} + irmod_pkg::TIMER_EXTRA;
                  else
                  begin
                     state_q <= irmod_pkg::ST_OFF;
                     timer_q <= {1'b0, off_len_q} + irmod_pkg::TIMER_EXTRA;
                  end
               end
               else
               begin
                  if (cnt_q != irmod_pkg::CNT_RST)
                     cnt_q <= cnt_q - irmod_pkg::CNT_ONE;
                  if (burst_done)
                     state_q <= irmod_pkg::ST_IDLE;
                  else if (long_mode)
                     // Stay active; OFF time is skipped
                     timer_q <= {1'b0, on_len_q} + irmod_pkg::TIMER_EXTRA;
                  else
                  begin
                     state_q <= irmod_pkg::ST_OFF;
                     timer_q <= {1'b0, off_len_q} + irmod_pkg::TIMER_EXTRA;
                  end
               end
            end
            irmod_pkg::ST_OFF:
            begin
               if (timer_q != 9'h000)
                  timer_q <= timer_q - 9'h001;
               else
               begin
                  state_q <= irmod_pkg::ST_ON;
                  timer_q <= {1'b0, on_len_q} + irmod_pkg::TIMER_EXTRA;
                  phase_q <= irmod_pkg::PHASE_RST;
               end
            end
            default:
               state_q <= irmod_pkg::ST_IDLE;
         endcase
         // High bits write; does not start a burst
         if (wr_en && (op_addr_i == irmod_pkg::ADDR_CNT_HIGH))
            cnt_q[irmod_pkg::CNT_HIGH_MSB:irmod_pkg::CNT_HIGH_LSB]
               <= new_val[1:0];
      end
   end

   // Interrupt flag: the set wins over either clear
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         mod_irq_o <= 1'b0;
      else if (burst_done)
         mod_irq_o <= 1'b1;
      else if (load_low)
         mod_irq_o <= 1'b0;
      else if (ctrl_wr && new_val[irmod_pkg::CTRL_RINT_BIT])
         mod_irq_o <= 1'b0;
   end

   // Active-low drive; chop keeps 2 of every 4 ON cycles active
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         pulse_out_n_o <= 1'b1;
      else
         pulse_out_n_o <= !((state_q == irmod_pkg::ST_ON)
            && !(chop_mode && phase_q[irmod_pkg::CHOP_BIT]));
   end

   property p_on_load;
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q == irmod_pkg::ST_ON && $past(state_q) != irmod_pkg::ST_ON)
      |-> timer_q == ({1'b0, $past(on_len_q)} + 9'h001);
   endproperty
   a_on_load: assert property (p_on_load)
      else $error("ON timer not loaded with value plus one");

   property p_off_load;
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q == irmod_pkg::ST_OFF && $past(state_q) == irmod_pkg::ST_ON)
      |-> timer_q == ({1'b0, $past(off_len_q)} + 9'h001);
   endproperty
   a_off_load: assert property (p_off_load)
      else $error("OFF timer not loaded with value plus one");

   property p_start;
      @(posedge clk_i) disable iff (sys_rst_i)
      load_low |=> state_q == irmod_pkg::ST_ON ##1 !pulse_out_n_o;
   endproperty
   a_start: assert property (p_start)
      else $error("Count load did not start a pulse");

   property p_countdown;
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q != irmod_pkg::ST_IDLE && timer_q != 9'h000 && !load_low)
      |=> timer_q == $past(timer_q) - 9'h001;
   endproperty
   a_countdown: assert property (p_countdown)
      else $error("Pulse timer did not count down");

   property p_done_irq;
      @(posedge clk_i) disable iff (sys_rst_i)
      burst_done
      |=> (mod_irq_o && state_q != irmod_pkg::ST_ON) || $past(load_low);
   endproperty
   a_done_irq: assert property (p_done_irq)
      else $error("Burst end did not raise interrupt");

   property p_load_clr;
      @(posedge clk_i) disable iff (sys_rst_i)
      (load_low && !burst_done) |=> !mod_irq_o;
   endproperty
   a_load_clr: assert property (p_load_clr)
      else $error("Count load did not clear interrupt");

   property p_rint_clr;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_wr && new_val[irmod_pkg::CTRL_RINT_BIT] && !burst_done)
      |=> !mod_irq_o;
   endproperty
   a_rint_clr: assert property (p_rint_clr)
      else $error("Interrupt clear strobe had no effect");

   property p_wdt;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_wr && new_val[irmod_pkg::CTRL_WDT_BIT])
      |=> watchdog_reload_strobe_o;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("Watchdog reload strobe missing");

   property p_cont;
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q != irmod_pkg::ST_IDLE && cont_mode)
      |=> state_q != irmod_pkg::ST_IDLE;
   endproperty
   a_cont: assert property (p_cont)
      else $error("Continuous mode stopped");

   property p_long;
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q == irmod_pkg::ST_ON && long_mode && !load_low)
      |=> state_q != irmod_pkg::ST_OFF;
   endproperty
   a_long: assert property (p_long)
      else $error("Long pulse entered OFF time");

   property p_chop;
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q == irmod_pkg::ST_ON && chop_mode
         && phase_q[irmod_pkg::CHOP_BIT]) |=> pulse_out_n_o;
   endproperty
   a_chop: assert property (p_chop)
      else $error("Carrier chop did not release output");

   property p_read;
      @(posedge clk_i) disable iff (sys_rst_i)
      (op_valid_i && op_code_i == irmod_pkg::DERIV_READ)
      |=> rd_valid_o && rd_data_o == $past(cur_val);
   endproperty
   a_read: assert property (p_read)
      else $error("Read answer wrong or late");

   property p_ctrl_rd;
      @(posedge clk_i) disable iff (sys_rst_i)
      (op_valid_i && op_code_i == irmod_pkg::DERIV_READ
         && op_addr_i == irmod_pkg::ADDR_CONTROL) |=> rd_data_o[7:3] == 5'h00;
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd)
      else $error("Control read shows strobe or reserved bits");

   property p_reset;
      @(posedge clk_i) sys_rst_i |=> pulse_out_n_o && !mod_irq_o;
   endproperty
   a_reset: assert property (p_reset)
      else $error("Output not inactive after reset");

endmodule : ir_pulse_burst_modulator

`default_nettype wire

// File: verif/core_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_model
(
   input  wire logic       clk_i,
   output var  logic       op_valid_o,
   output var  logic [1:0] op_code_o,
   output var  logic [2:0] op_addr_o,
   output var  logic [7:0] acc_data_o,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i
);
   // Idle instruction port at time zero
   initial
   begin
      op_valid_o = 1'b0;
      op_code_o  = 2'h0;
      op_addr_o  = 3'h0;
      acc_data_o = 8'h00;
   end

   // One instruction per call, launched and retired at falling edges
   task automatic op(input logic [1:0] c, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] r);
      @(negedge clk_i);
      op_valid_o = 1'b1;
      op_code_o  = c;
      op_addr_o  = a;
      acc_data_o = d;
      @(negedge clk_i);
      op_valid_o = 1'b0;
      acc_data_o = ~d; // Stale accumulator never lingers
      r = (rd_valid_i === 1'b1) ? rd_data_i : 8'hXX;
   endtask : op
endmodule : core_model

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
      end \
   end

module tb_top;
   logic       clk_i;
   logic       sys_rst_i;
   logic       op_valid;
   logic [1:0] op_code;
   logic [2:0] op_addr;
   logic [7:0] acc_data;
   logic [7:0] rd_data_o;
   logic       rd_valid_o;
   logic       pulse_out_n_o;
   logic       mod_irq_o;
   logic       watchdog_reload_strobe_o;
   logic [7:0] r;
   int         n;
   int         n_fail;
   int         checks_done;

   ir_pulse_burst_modulator u_ir_pulse_burst_modulator
   (
      .clk_i                    (clk_i),
      .sys_rst_i                (sys_rst_i),
      .op_valid_i               (op_valid),
      .op_code_i                (op_code),
      .op_addr_i                (op_addr),
      .acc_data_i               (acc_data),
      .rd_data_o                (rd_data_o),
      .rd_valid_o               (rd_valid_o),
      .pulse_out_n_o            (pulse_out_n_o),
      .mod_irq_o                (mod_irq_o),
      .watchdog_reload_strobe_o (watchdog_reload_strobe_o)
   );

   core_model u_core_model
   (
      .clk_i      (clk_i),
      .op_valid_o (op_valid),
      .op_code_o  (op_code),
      .op_addr_o  (op_addr),
      .acc_data_o (acc_data),
      .rd_data_i  (rd_data_o),
      .rd_valid_i (rd_valid_o)
   );

   // 20 MHz oscillator
   initial clk_i = 1'b0;
   always #25 clk_i = ~clk_i;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] x;
      u_core_model.op(irmod_pkg::DERIV_WRITE, a, d, x);
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      u_core_model.op(irmod_pkg::DERIV_READ, a, 8'h00, q);
   endtask : rd

   // Count falling-edge samples of the output at one level, capped
   task automatic run(input logic lvl, input int lim, output int k);
      k = 0;
      while (pulse_out_n_o === lvl && k < lim)
      begin
         @(negedge clk_i);
         k++;
      end
   endtask : run

   // Program a burst; the low byte write launches it
   task automatic burst(input logic [7:0] c, input logic [7:0] on,
                        input logic [7:0] off, input logic [9:0] cnt);
      wr(irmod_pkg::ADDR_CONTROL, c);
      wr(irmod_pkg::ADDR_ON_LEN, on);
      wr(irmod_pkg::ADDR_OFF_LEN, off);
      wr(irmod_pkg::ADDR_CNT_HIGH, {6'h00, cnt[9:8]});
      wr(irmod_pkg::ADDR_CNT_LOW, cnt[7:0]);
      `CHK("irq on load", 1'b0, mod_irq_o)
      run(1'b1, 10, n);
   endtask : burst

   // Expect k low runs of lo samples, each followed by hi high samples
   task automatic pulses(input int k, input int lo, input int hi);
      for (int i = 0; i < k; i++)
      begin
         run(1'b0, 3000, n);
         `CHK("low run", lo, n)
         run(1'b1, hi, n);
         `CHK("high run", hi, n)
      end
   endtask : pulses

   // Hang guard at 8000 cycles, far beyond the thousand or so cycles the tests need
   initial
   begin
      #(50 * 8000);
      n_fail++;
      report_and_stop();
   end

   initial
   begin
      n_fail = 0;
      checks_done = 0;
      sys_rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      `CHK("out idle", 1'b1, pulse_out_n_o)
      `CHK("irq idle", 1'b0, mod_irq_o)
      for (int a = 0; a < 8; a++)
      begin
         rd(a[2:0], r);
         `CHK("reset read", 8'h00, r)
      end
      $display("test reset done");

      wr(3'h5, 8'hFF);
      rd(3'h5, r);
      `CHK("unmapped", 8'h00, r)
      wr(irmod_pkg::ADDR_ON_LEN, 8'hA5);
      rd(irmod_pkg::ADDR_ON_LEN, r);
      `CHK("on length", 8'hA5, r)
      u_core_model.op(irmod_pkg::DERIV_AND, 3'h0, 8'h0F, r);
      rd(irmod_pkg::ADDR_ON_LEN, r);
      `CHK("and result", 8'h05, r)
      u_core_model.op(irmod_pkg::DERIV_OR, 3'h0, 8'h30, r);
      rd(irmod_pkg::ADDR_ON_LEN, r);
      `CHK("or result", 8'h35, r)
      wr(irmod_pkg::ADDR_OFF_LEN, 8'h5A);
      rd(irmod_pkg::ADDR_OFF_LEN, r);
      `CHK("off length", 8'h5A, r)
      wr(irmod_pkg::ADDR_CNT_HIGH, 8'hFF);
      rd(irmod_pkg::ADDR_CNT_HIGH, r);
      `CHK("count high", 8'h03, r)
      wr(irmod_pkg::ADDR_CNT_HIGH, 8'h00);
      wr(irmod_pkg::ADDR_CONTROL, 8'hFF);
      `CHK("wdt strobe", 1'b1, watchdog_reload_strobe_o)
      rd(irmod_pkg::ADDR_CONTROL, r);
      `CHK("control", 8'h07, r)
      `CHK("strobe once", 1'b0, watchdog_reload_strobe_o)
      $display("test registers done");

      burst(8'h00, 8'h01, 8'h03, 10'h003);
      pulses(3, 3, 5);
      `CHK("irq done", 1'b1, mod_irq_o)
      run(1'b1, 200, n);
      `CHK("burst ended", 200, n)
      wr(irmod_pkg::ADDR_CONTROL, 8'h08);
      `CHK("irq cleared", 1'b0, mod_irq_o)
      $display("test burst done");

      burst(8'h02, 8'h01, 8'h09, 10'h004);
      pulses(1, 12, 50);
      `CHK("irq long", 1'b1, mod_irq_o)
      burst(8'h03, 8'h01, 8'h00, 10'h004);
      pulses(3, 2, 2);
      burst(8'h01, 8'h02, 8'h00, 10'h002);
      pulses(2, 2, 4);
      // Count above 255 pairs the high bits with the low byte
      burst(8'h02, 8'h00, 8'h00, 10'h101);
      pulses(1, 514, 20);
      `CHK("irq pair", 1'b1, mod_irq_o)
      $display("test modes done");

      burst(8'h04, 8'h00, 8'h00, 10'h001);
      pulses(5, 2, 2);
      `CHK("irq cont", 1'b0, mod_irq_o)
      // Long on top of continuous never lets go; skip the pulse in flight
      wr(irmod_pkg::ADDR_CONTROL, 8'h06);
      run(1'b0, 4, n);
      run(1'b1, 4, n);
      run(1'b0, 100, n);
      `CHK("steady long", 100, n)
      `CHK("irq steady", 1'b0, mod_irq_o)
      sys_rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      `CHK("out reset", 1'b1, pulse_out_n_o)
      rd(irmod_pkg::ADDR_CONTROL, r);
      `CHK("control reset", 8'h00, r)
      $display("test continuous done");
      report_and_stop();
   end
endmodule : tb_top

`default_nettype wire
